// File: src/amd_map_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module amd_map_decoder #(
  parameter logic [15:0] RAM_END   = amd_map_pkg::RAM_END_DEF,
  parameter logic [15:0] ROM_START = amd_map_pkg::ROM_START_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Core request on the shared address and data bus
  input  wire logic        core_req,
  input  wire logic        core_we,
  input  wire logic        core_byte,
  input  wire logic        core_fetch,
  input  wire logic [15:0] shared_address_bus,
  input  wire logic [15:0] shared_data_bus,
  // Core answer
  output logic [15:0]      core_rdata,
  output logic             core_rvalid,
  output logic             core_err,
  // Target selects
  output logic             sel_low_special_registers,
  output logic             sel_per8,
  output logic             sel_per16,
  output logic             sel_ram,
  output logic             sel_rom,
  output logic             sel_none,
  output logic             vec_hit,
  // Target side of the bus
  output logic [15:0]      tgt_addr,
  output logic [15:0]      tgt_wdata,
  output logic [1:0]       tgt_be,
  output logic             tgt_we,
  input  wire logic [15:0] tgt_rdata
);

  // ==========================================================
  // Region decode
  logic r_lsr;
  logic r_per8;
  logic r_per16;
  logic r_ram;
  logic r_rom;
  logic odd;
  logic bad;

  always_comb begin
    odd     = shared_address_bus[0];
    r_lsr   = shared_address_bus < amd_map_pkg::PER8_BASE;
    r_per8  = !r_lsr && shared_address_bus < amd_map_pkg::PER16_BASE;
    r_per16 = shared_address_bus >= amd_map_pkg::PER16_BASE &&
              shared_address_bus < amd_map_pkg::RAM_BASE;
    r_ram   = shared_address_bus >= amd_map_pkg::RAM_BASE &&
              shared_address_bus <= RAM_END;
    r_rom   = shared_address_bus >= ROM_START &&
              shared_address_bus <= amd_map_pkg::ROM_TOP;
    // Refused accesses
    bad = (core_fetch && odd)
        || (!core_byte && odd)
        || (r_lsr && !core_byte)
        || (r_per16 && core_byte && odd);
  end

  // ==========================================================
  // Request stage
  logic        next_sel_lsr;
  logic        next_sel_per8;
  logic        next_sel_per16;
  logic        next_sel_ram;
  logic        next_sel_rom;
  logic        next_sel_none;
  logic        next_vec_hit;
  logic [15:0] next_tgt_addr;
  logic [15:0] next_tgt_wdata;
  logic [1:0]  next_tgt_be;
  logic        next_tgt_we;
  logic        next_err;
  logic        rd_pend;
  logic        rd_byte;
  logic        rd_odd;
  logic        next_rd_pend;
  logic        next_rd_byte;
  logic        next_rd_odd;

  always_comb begin
    next_sel_lsr   = 1'b0;
    next_sel_per8  = 1'b0;
    next_sel_per16 = 1'b0;
    next_sel_ram   = 1'b0;
    next_sel_rom   = 1'b0;
    next_sel_none  = 1'b0;
    next_vec_hit   = 1'b0;
    next_tgt_addr  = tgt_addr;
    next_tgt_wdata = tgt_wdata;
    next_tgt_be    = amd_map_pkg::BE_NONE;
    next_tgt_we    = 1'b0;
    next_err       = 1'b0;
    next_rd_pend   = 1'b0;
    next_rd_byte   = rd_byte;
    next_rd_odd    = rd_odd;
    if (core_req) begin
      next_tgt_addr = shared_address_bus;
      next_rd_byte  = core_byte;
      next_rd_odd   = odd;
      if (bad) begin
        next_sel_none = 1'b1;
        next_err      = 1'b1;
      end else begin
        // One-hot select by region
        next_sel_lsr   = r_lsr;
        next_sel_per8  = r_per8;
        next_sel_per16 = r_per16;
        next_sel_ram   = r_ram;
        next_sel_rom   = r_rom;
        next_sel_none  = !(r_lsr || r_per8 || r_per16 || r_ram || r_rom);
        next_err       = next_sel_none;
        next_vec_hit   = r_rom && shared_address_bus >= amd_map_pkg::VEC_BASE;
        next_tgt_we    = core_we && !next_sel_none;
        next_rd_pend   = !core_we && !next_sel_none;
        // Little-endian lanes: low byte at even address
        if (core_byte) begin
          next_tgt_be    = odd ? amd_map_pkg::BE_HIGH : amd_map_pkg::BE_LOW;
          next_tgt_wdata = {shared_data_bus[7:0], shared_data_bus[7:0]};
        end else if (r_per8) begin
          next_tgt_be    = amd_map_pkg::BE_LOW;
          next_tgt_wdata = {amd_map_pkg::BYTE_ZERO, shared_data_bus[7:0]};
        end else begin
          next_tgt_be    = amd_map_pkg::BE_WORD;
          next_tgt_wdata = shared_data_bus;
        end
        if (next_sel_none) begin
          next_tgt_be = amd_map_pkg::BE_NONE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_low_special_registers <= 1'b0;
      sel_per8  <= 1'b0;
      sel_per16 <= 1'b0;
      sel_ram   <= 1'b0;
      sel_rom   <= 1'b0;
      sel_none  <= 1'b0;
      vec_hit   <= 1'b0;
      tgt_addr  <= amd_map_pkg::WORD_ZERO;
      tgt_wdata <= amd_map_pkg::WORD_ZERO;
      tgt_be    <= amd_map_pkg::BE_NONE;
      tgt_we    <= 1'b0;
      core_err  <= 1'b0;
      rd_pend   <= 1'b0;
      rd_byte   <= 1'b0;
      rd_odd    <= 1'b0;
    end else begin
      sel_low_special_registers <= next_sel_lsr;
      sel_per8  <= next_sel_per8;
      sel_per16 <= next_sel_per16;
      sel_ram   <= next_sel_ram;
      sel_rom   <= next_sel_rom;
      sel_none  <= next_sel_none;
      vec_hit   <= next_vec_hit;
      tgt_addr  <= next_tgt_addr;
      tgt_wdata <= next_tgt_wdata;
      tgt_be    <= next_tgt_be;
      tgt_we    <= next_tgt_we;
      core_err  <= next_err;
      rd_pend   <= next_rd_pend;
      rd_byte   <= next_rd_byte;
      rd_odd    <= next_rd_odd;
    end
  end

  // ==========================================================
  // Read return stage
  logic [15:0] next_core_rdata;
  logic        next_core_rvalid;

  always_comb begin
    next_core_rvalid = rd_pend;
    next_core_rdata  = core_rdata;
    if (rd_pend) begin
      if (rd_byte) begin
        // Byte lands in the low lane
        next_core_rdata = {amd_map_pkg::BYTE_ZERO,
                           rd_odd ? tgt_rdata[15:8] : tgt_rdata[7:0]};
      end else if (sel_per8) begin
        // High byte has no meaning here; zero is given
        next_core_rdata = {amd_map_pkg::BYTE_ZERO, tgt_rdata[7:0]};
      end else begin
        next_core_rdata = tgt_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_rdata  <= amd_map_pkg::WORD_ZERO;
      core_rvalid <= 1'b0;
    end else begin
      core_rdata  <= next_core_rdata;
      core_rvalid <= next_core_rvalid;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_onehot;
    core_req |=> $onehot({sel_low_special_registers, sel_per8, sel_per16,
                          sel_ram, sel_rom, sel_none});
  endproperty
  a_onehot: assert property (p_onehot) else $error("select not one-hot");

  property p_idle;
    !core_req |=> !(sel_low_special_registers || sel_per8 || sel_per16 ||
                    sel_ram || sel_rom || sel_none || tgt_we);
  endproperty
  a_idle: assert property (p_idle) else $error("select without request");

  property p_odd_fetch;
    core_req && core_fetch && shared_address_bus[0] |=> core_err && sel_none;
  endproperty
  a_odd_fetch: assert property (p_odd_fetch) else $error("odd fetch taken");

  property p_addr_pass;
    core_req |=> tgt_addr == $past(shared_address_bus);
  endproperty
  a_addr_pass: assert property (p_addr_pass) else $error("address altered");

  property p_rom;
    core_req && core_byte && !core_fetch && shared_address_bus >= ROM_START |=> sel_rom;
  endproperty
  a_rom: assert property (p_rom) else $error("flash not selected");

  property p_vec;
    vec_hit |-> sel_rom && tgt_addr >= 16'hFFE0 && tgt_addr <= 16'hFFFF;
  endproperty
  a_vec: assert property (p_vec) else $error("vector hit outside table");

  property p_ram;
    core_req && !core_byte && !shared_address_bus[0] &&
      shared_address_bus >= 16'h0200 && shared_address_bus <= RAM_END
      |=> sel_ram && tgt_be == 2'h3;
  endproperty
  a_ram: assert property (p_ram) else $error("RAM word not selected");

  property p_per16;
    core_req && !core_byte && !shared_address_bus[0] &&
      shared_address_bus[15:8] == 8'h01 |=> sel_per16;
  endproperty
  a_per16: assert property (p_per16) else $error("16-bit peripheral missed");

  property p_per16_byte;
    core_req && core_byte && !core_we && shared_address_bus[15:8] == 8'h01 &&
      !shared_address_bus[0] |=> ##1 core_rvalid && core_rdata[15:8] == 8'h00;
  endproperty
  a_per16_byte: assert property (p_per16_byte) else $error("byte high not zero");

  property p_per8_word_wr;
    core_req && core_we && !core_byte && !shared_address_bus[0] &&
      shared_address_bus >= 16'h0010 && shared_address_bus <= 16'h00FF
      |=> sel_per8 && tgt_we && tgt_be == 2'h1;
  endproperty
  a_per8_word_wr: assert property (p_per8_word_wr) else $error("per8 high byte written");

  property p_sfr_word;
    core_req && !core_byte && shared_address_bus <= 16'h000F |=> core_err;
  endproperty
  a_sfr_word: assert property (p_sfr_word) else $error("word access to low registers taken");

  property p_word_odd;
    core_req && !core_byte && shared_address_bus[0] |=> sel_none && tgt_be == 2'h0;
  endproperty
  a_word_odd: assert property (p_word_odd) else $error("odd word taken");

  property p_per8_word_rd;
    core_req && !core_we && !core_byte && !shared_address_bus[0] &&
      shared_address_bus >= 16'h0010 && shared_address_bus <= 16'h00FF
      |=> ##1 core_rvalid && core_rdata[7:0] == $past(tgt_rdata[7:0]);
  endproperty
  a_per8_word_rd: assert property (p_per8_word_rd) else $error("per8 low byte lost");

endmodule
`default_nettype wire

// File: src/amd_map_pkg.sv
// What this block does
// - Core drives one address bus and one data bus; targets see a registered copy on tgt_addr and tgt_wdata.
// - Decoder covers a 64 KB space with a 16-bit byte address.
// - Flash/ROM region ends at 0FFFFh; its start is a parameter.
// - Vector table is the top 16 words of flash; top vector at 0FFFEh.
// - RAM starts at 0200h, end is a parameter, holds code and data.
// - Addresses 0100h to 01FFh select the 16-bit peripherals.
// - Byte access to 16-bit peripherals only at even address; high byte reads zero.
// - Addresses 010h to 0FFh select the 8-bit peripherals.
// - Word read of an 8-bit peripheral gives a valid low byte only.
// - Word write to an 8-bit peripheral writes the low byte only.
// - Lowest 16 bytes are byte-wide special registers, byte access only.
// - Words sit at even addresses, low byte even, high byte odd.
`default_nettype none
package amd_map_pkg;

  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ==========================================================
  // Region boundaries
  localparam logic [15:0] PER8_BASE     = 16'h0010;
  localparam logic [15:0] PER16_BASE    = 16'h0100;
  localparam logic [15:0] RAM_BASE      = 16'h0200;
  localparam logic [15:0] ROM_TOP       = 16'hFFFF;
  localparam logic [15:0] VEC_BASE      = 16'hFFE0;
  localparam logic [15:0] RESET_VEC     = 16'hFFFE;
  localparam logic [15:0] RAM_END_DEF   = 16'h09FF;
  localparam logic [15:0] ROM_START_DEF = 16'hC000;

  // ==========================================================
  // Byte lanes and reset values
  localparam logic [1:0]  BE_NONE  = 2'h0;
  localparam logic [1:0]  BE_LOW   = 2'h1;
  localparam logic [1:0]  BE_HIGH  = 2'h2;
  localparam logic [1:0]  BE_WORD  = 2'h3;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage
`default_nettype wire

// File: testbench/amd_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module amd_core_model (
  // Clock
  input  wire logic        clk,
  // Core request
  output var  logic        core_req,
  output var  logic        core_we,
  output var  logic        core_byte,
  output var  logic        core_fetch,
  output var  logic [15:0] shared_address_bus,
  output var  logic [15:0] shared_data_bus
);
  initial begin
    core_req = 1'b0;
    core_we = 1'b0;
    core_byte = 1'b0;
    core_fetch = 1'b0;
    shared_address_bus = 16'h0000;
    shared_data_bus = 16'h0000;
  end

  // ==========================================================
  // One access, held across exactly one taking edge
  task automatic access(input logic we, input logic byt, input logic fetch,
                        input logic [15:0] addr, input logic [15:0] data);
    @(negedge clk);
    core_req = 1'b1;
    core_we = we;
    core_byte = byt;
    core_fetch = fetch;
    shared_address_bus = addr;
    shared_data_bus = data;
    @(negedge clk);
    core_req = 1'b0;
    // Released bus shows no stale value
    shared_address_bus = ~addr;
    shared_data_bus = ~data;
  endtask
endmodule
`default_nettype wire

// File: testbench/address_map_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module address_map_decoder_test;
  localparam logic [5:0] LSR = 6'h20, P8 = 6'h10, P16 = 6'h08;
  localparam logic [5:0] RAM = 6'h04, ROM = 6'h02, NON = 6'h01;
  logic        clk, resetn, core_req, core_we, core_byte, core_fetch;
  logic [15:0] shared_address_bus, shared_data_bus, core_rdata;
  logic [15:0] tgt_addr, tgt_wdata, tgt_rdata;
  logic        core_rvalid, core_err, tgt_we, vec_hit;
  wire  [5:0]  sel;
  logic [1:0]  tgt_be;
  int          num_errors = 0;
  int          num_checks = 0;

  // Target answers with an address-dependent pattern
  assign tgt_rdata = tgt_addr ^ 16'h5AA5;

  amd_core_model amd_core_model_i (.clk(clk), .core_req(core_req), .core_we(core_we),
    .core_byte(core_byte), .core_fetch(core_fetch),
    .shared_address_bus(shared_address_bus), .shared_data_bus(shared_data_bus));
  amd_map_decoder amd_map_decoder_i (.clk(clk), .resetn(resetn), .core_req(core_req),
    .core_we(core_we), .core_byte(core_byte), .core_fetch(core_fetch),
    .shared_address_bus(shared_address_bus), .shared_data_bus(shared_data_bus),
    .core_rdata(core_rdata), .core_rvalid(core_rvalid), .core_err(core_err),
    .sel_low_special_registers(sel[5]), .sel_per8(sel[4]), .sel_per16(sel[3]),
    .sel_ram(sel[2]), .sel_rom(sel[1]), .sel_none(sel[0]), .vec_hit(vec_hit),
    .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_be(tgt_be), .tgt_we(tgt_we),
    .tgt_rdata(tgt_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // One access, judged at the select cycle and the answer cycle
  task automatic xfer(input logic we, input logic byt, input logic fetch,
                      input logic [15:0] a, input logic [15:0] d, input logic [5:0] s);
    logic [15:0] r;
    logic [1:0]  be;
    r = a ^ 16'h5AA5;
    be = byt ? (a[0] ? 2'h2 : 2'h1) : ((s == P8) ? 2'h1 : 2'h3);
    amd_core_model_i.access(we, byt, fetch, a, d);
    check({10'h000, sel}, {10'h000, s});
    check({15'h0000, core_err}, {15'h0000, s == NON});
    check({15'h0000, vec_hit}, {15'h0000, s == ROM && a >= 16'hFFE0});
    check({15'h0000, tgt_we}, {15'h0000, we && s != NON});
    if (s == NON) check({14'h0000, tgt_be}, 16'h0000);
    else check({14'h0000, tgt_be}, {14'h0000, be});
    if (s != NON) check(tgt_addr, a);
    if (we && s != NON)
      check(tgt_wdata, byt ? {d[7:0], d[7:0]} : (s == P8 ? {8'h00, d[7:0]} : d));
    @(negedge clk);
    check({15'h0000, core_rvalid}, {15'h0000, !we && s != NON});
    if (!we && s != NON) begin
      if (byt) check(core_rdata, {8'h00, a[0] ? r[15:8] : r[7:0]});
      else if (s == P8) check(core_rdata[7:0], {8'h00, r[7:0]});
      else check(core_rdata, r);
    end
  endtask

  task automatic t_reset;
    check({9'h000, sel, core_err}, 16'h0000);
    check(tgt_addr, 16'h0000);
    check({13'h0000, tgt_we, tgt_be}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_regions;
    xfer(0, 1, 0, 16'h000F, 16'h0000, LSR);
    xfer(0, 1, 0, 16'h0010, 16'h0000, P8);
    xfer(0, 0, 0, 16'h00FE, 16'h0000, P8);
    xfer(0, 0, 0, 16'h0100, 16'h0000, P16);
    xfer(0, 0, 0, 16'h01FE, 16'h0000, P16);
    xfer(0, 0, 1, 16'h0200, 16'h0000, RAM);
    xfer(0, 0, 0, 16'h09FE, 16'h0000, RAM);
    xfer(0, 0, 0, 16'h0A00, 16'h0000, NON);
    xfer(0, 0, 0, 16'hBFFE, 16'h0000, NON);
    xfer(0, 0, 1, 16'hC000, 16'h0000, ROM);
    xfer(0, 0, 0, 16'hFFDE, 16'h0000, ROM);
    xfer(0, 0, 0, 16'hFFE0, 16'h0000, ROM);
    xfer(0, 0, 1, 16'hFFFE, 16'h0000, ROM);
    xfer(0, 1, 0, 16'hFFFF, 16'h0000, ROM);
    $display("test regions done");
  endtask

  task automatic t_refused;
    xfer(0, 0, 0, 16'h0203, 16'h0000, NON);
    xfer(0, 0, 1, 16'h0201, 16'h0000, NON);
    xfer(0, 1, 1, 16'hC001, 16'h0000, NON);
    xfer(1, 0, 0, 16'h0004, 16'h1234, NON);
    xfer(0, 1, 0, 16'h0101, 16'h0000, NON);
    xfer(0, 1, 0, 16'h0102, 16'h0000, P16);
    $display("test refused done");
  endtask

  task automatic t_writes;
    xfer(1, 1, 0, 16'h0011, 16'h77AB, P8);
    xfer(1, 0, 0, 16'h0020, 16'h1234, P8);
    xfer(1, 0, 0, 16'h0300, 16'hBEEF, RAM);
    xfer(1, 1, 0, 16'h0006, 16'h00C3, LSR);
    xfer(1, 0, 0, 16'h0104, 16'hA5A5, P16);
    $display("test writes done");
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_regions();
    t_refused();
    t_writes();
    final_report();
  end

  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
